/* hw/fmcf_core.sv */
/*
  Top of the fan monitor control core: register file, monitoring start,
  fail-safe timing, temperature encoding, fan drive, shared pin and XOR test.
  Assumes tempIn is a signed quarter-degree reading on the core clock and that
  the pins outside are open drain with pull-ups.
*/
`timescale 1ns/100ps
module fmcf_core #(
  parameter int HF_PERIOD_CYC  = fmcf_pkg::HF_PERIOD_DFLT,
  parameter int LF_FAST_CYC    = fmcf_pkg::LF_FAST_DFLT,
  parameter int FAILSAFE_CYC   = fmcf_pkg::FAILSAFE_DFLT,
  parameter int THERMAL_EVENT_PIN_TICK_CYC = fmcf_pkg::THERMAL_EVENT_PIN_TICK_DFLT
) (
  input  wire logic                        clock,
  input  wire logic                        arst_n,
  input  wire logic                        scl,
  input  wire logic                        sdaIn,
  output logic                             sdaOut,
  output logic                             sdaOe,
  input  wire logic                        processorCoreSupply,
  input  wire logic [4:0]                  voltageIdInput,
  input  wire logic                        voltageIdSixthInput,
  input  wire logic [fmcf_pkg::TEMP_W-1:0] tempIn,
  input  wire logic                        fan4PinIn,
  output logic                             fan4PinOut,
  output logic                             fan4PinOe,
  output logic                             fan1DriveOutput,
  output logic                             monitorEnable,
  output logic                             fanFullSpeed
);
  import fmcf_pkg::*;

  fmcf_link_if link ();

  // ********************************
  // Serial link
  // ********************************
  fmcf_smbus_slave u_slave (
    .scl    (scl),
    .arst_n (arst_n),
    .sdaIn  (sdaIn),
    .sdaOut (sdaOut),
    .sdaOe  (sdaOe),
    .link   (link.slave)
  );

  // ********************************
  // Pin and toggle synchronisers
  // ********************************
  logic [7:0] pinMeta_q;
  logic [7:0] pinSync_q;
  logic [2:0] tglMeta_q;
  logic [2:0] tglSync_q;
  logic [2:0] tglPrev_q;

  wire [7:0] pinRaw = {fan4PinIn, processorCoreSupply,
                       voltageIdSixthInput, voltageIdInput};
  wire [2:0] tglRaw = {link.doneTgl, link.ptrTgl, link.wrTgl};

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta_q <= 8'h00;
      pinSync_q <= 8'h00;
      tglMeta_q <= 3'h0;
      tglSync_q <= 3'h0;
      tglPrev_q <= 3'h0;
    end else begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
      tglMeta_q <= tglRaw;
      tglSync_q <= tglMeta_q;
      tglPrev_q <= tglSync_q;
    end
  end

  wire [5:0] voltPins  = pinSync_q[5:0];
  wire       supplyNow = pinSync_q[6];
  wire       pinLevel  = pinSync_q[7];
  wire [2:0] evt       = tglSync_q ^ tglPrev_q;
  wire       wrEvt     = evt[0];
  wire       ptrEvt    = evt[1];
  wire       doneEvt   = evt[2];

  // ********************************
  // Register file
  // ********************************
  logic [7:0] duty_q;
  logic [7:0] maxDuty_q;
  logic [7:0] limit_q;
  logic [7:0] offset_q;
  logic [7:0] lfDiv_q;
  logic [7:0] cfg5_q;
  logic [7:0] cfg4_q;
  logic [7:0] volt_q;
  logic [7:0] ptrCore_q;
  logic [7:0] rdData_q;

  wire [7:0] wrAddr  = link.ptr;
  wire [7:0] wrData  = link.wrData;
  wire wrDuty   = wrEvt && (wrAddr == REG_DUTY);
  wire wrMax    = wrEvt && (wrAddr == REG_MAXDUTY);
  wire wrLimit  = wrEvt && (wrAddr == REG_LIMIT);
  wire wrOffset = wrEvt && (wrAddr == REG_OFFSET);
  wire wrLfDiv  = wrEvt && (wrAddr == REG_LFDIV);
  wire wrCfg5   = wrEvt && (wrAddr == REG_CFG5);
  wire wrCfg4   = wrEvt && (wrAddr == REG_CFG4);
  wire wrThTime = wrEvt && (wrAddr == REG_THTIME);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      duty_q    <= DUTY_RST;
      maxDuty_q <= MAXDUTY_RST;
      limit_q   <= LIMIT_RST; // R10
      offset_q  <= OFFSET_RST;
      lfDiv_q   <= LFDIV_RST;
      cfg5_q    <= CFG5_RST;
      cfg4_q    <= CFG4_RST;
    end else begin
      if (wrDuty) duty_q <= wrData; // R8
      if (wrMax) maxDuty_q <= wrData;
      if (wrLimit) limit_q <= wrData;
      if (wrOffset) offset_q <= wrData;
      if (wrLfDiv) lfDiv_q <= wrData;
      if (wrCfg5) cfg5_q <= wrData;
      if (wrCfg4) cfg4_q <= wrData;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      volt_q    <= 8'h00;
      ptrCore_q <= 8'h00;
    end else begin
      volt_q <= {2'b00, voltPins}; // R17
      if (ptrEvt) ptrCore_q <= link.ptr;
    end
  end

  // ********************************
  // Monitoring start and fail-safe
  // ********************************
  logic            supplyPrev_q;
  logic            monitor_q;
  logic            fsArmed_q;
  logic            failsafe_q;
  logic [FS_W-1:0] fsCnt_q;

  wire supplyRise = supplyNow && !supplyPrev_q;
  wire fsCancel   = doneEvt || wrEvt;
  wire fsExpire   = fsArmed_q && (fsCnt_q == '0) && !supplyRise;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      supplyPrev_q <= 1'b0;
      monitor_q    <= 1'b0;
    end else begin
      supplyPrev_q <= supplyNow;
      if (supplyRise) monitor_q <= 1'b1; // R3
      else if (doneEvt) monitor_q <= 1'b1; // R4
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fsArmed_q <= 1'b0;
      fsCnt_q   <= '0;
    end else if (supplyRise) begin
      fsArmed_q <= 1'b1; // R7
      fsCnt_q   <= FS_W'(FAILSAFE_CYC - 1); // R22
    end else if (fsCancel || fsExpire) begin
      fsArmed_q <= 1'b0; // R22
    end else if (fsArmed_q) begin
      fsCnt_q <= fsCnt_q - 1'b1; // R5
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) failsafe_q <= 1'b0;
    else if (fsExpire) failsafe_q <= 1'b1; // R5
    else if (wrEvt) failsafe_q <= 1'b0; // R8
  end

  // ********************************
  // Temperature offset and encoding
  // ********************************
  logic [7:0] tempRead_q;
  logic       hot_q;

  wire twosRange = cfg5_q[CFG5_RANGE];
  wire signed [10:0] tempSum = $signed({tempIn[TEMP_W-1], tempIn}) +
                               $signed({{2{offset_q[7]}}, offset_q, 1'b0}); // R11
  wire signed [8:0] tempInt = tempSum[10:2];
  wire signed [9:0] tempExt = $signed({tempInt[8], tempInt}) + EXT_BIAS; // R10
  wire [7:0] encExt  = tempExt[9] ? 8'h00 :
                       (tempExt[8] ? 8'hff : tempExt[7:0]);
  wire       twosHi  = (tempInt > $signed(9'sh07f));
  wire       twosLo  = (tempInt < $signed(9'sh181));
  wire [7:0] encTwos = twosHi ? TWOS_MAX :
                       (twosLo ? TWOS_MIN : tempInt[7:0]); // R9
  wire [7:0] tempEnc = twosRange ? encTwos : encExt; // R9
  wire hotNow = twosRange ? ($signed(tempEnc) > $signed(limit_q)) :
                (tempEnc > limit_q); // R6

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tempRead_q <= 8'h00;
      hot_q      <= 1'b0;
    end else begin
      tempRead_q <= tempEnc;
      hot_q      <= hotNow;
    end
  end

  // ********************************
  // Fan drive
  // ********************************
  logic [PWM_W-1:0] pwmCnt_q;
  logic             pwm_q;
  logic             fan1_q;

  wire       lowFreq = cfg5_q[CFG5_LOWFREQ];
  wire [3:0] divRaw  = lfDiv_q[3:0];
  wire [3:0] divEff  = (divRaw == 4'd0) ? 4'd1 :
                       ((divRaw > LF_DIV_MAX) ? LF_DIV_MAX : divRaw);
  wire [PWM_W+3:0] lfProd = PWM_W'(LF_FAST_CYC) * divEff;
  wire [PWM_W-1:0] lfPeriod = lfProd[PWM_W-1:0]; // R2
  wire [PWM_W-1:0] hfPeriod = PWM_W'(HF_PERIOD_CYC); // R1
  wire [PWM_W-1:0] period = lowFreq ? lfPeriod : hfPeriod;
  wire       fullSpeed = failsafe_q || hot_q;
  wire [7:0] dutyCap = (duty_q > maxDuty_q) ? maxDuty_q : duty_q; // R12
  wire [7:0] dutyEff = fullSpeed ? 8'hff : dutyCap; // R6
  wire [PWM_W+7:0] onProd = dutyEff * period;
  wire [PWM_W-1:0] onCyc  = onProd[PWM_W+7:8];
  wire pwmWrap = (pwmCnt_q >= period - 1'b1);
  wire pwmHigh = (dutyEff == 8'hff) || (pwmCnt_q < onCyc);
  wire xorTree = ^pinSync_q;
  wire xorTest = cfg4_q[CFG4_XOR];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pwmCnt_q <= '0;
      pwm_q    <= 1'b0;
      fan1_q   <= 1'b0;
    end else begin
      pwmCnt_q <= pwmWrap ? '0 : pwmCnt_q + 1'b1;
      pwm_q    <= pwmHigh;
      fan1_q   <= xorTest ? xorTree : pwm_q; // R19
    end
  end

  // ********************************
  // Shared pin
  // ********************************
  logic [TICK_W-1:0] tick_q;
  logic [7:0]        thTime_q;
  logic              pinDrv_q;

  wire [1:0] pinSel  = cfg4_q[1:0]; // R21
  wire gpioDir = cfg5_q[CFG5_GPIO_DIR]; // R13
  wire gpioPol = cfg5_q[CFG5_GPIO_POL]; // R14
  wire gpioVal = cfg5_q[CFG5_GPIO_VAL];
  wire gpioLvl = gpioPol ? gpioVal : ~gpioVal; // R14
  wire gpioSt  = gpioPol ? pinLevel : ~pinLevel; // R14
  wire selGpio  = (pinSel == PIN_GPIO);
  wire selTherm = (pinSel == PIN_THERMAL_EVENT_PIN);
  wire selAlert = (pinSel == PIN_ALERT);
  wire thermIn  = selTherm && !pinLevel && !pinDrv_q; // R18
  wire pinDrvD  = (selGpio && gpioDir && !gpioLvl) || // R13
                  (selTherm && hot_q) || // R18
                  (selAlert && hot_q); // R20
  wire tickEnd  = (tick_q == TICK_W'(THERMAL_EVENT_PIN_TICK_CYC - 1));
  wire thInc    = thermIn && tickEnd && (thTime_q != 8'hff);
  wire pinState = selGpio ? gpioSt : thermIn; // R15

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tick_q   <= '0;
      thTime_q <= 8'h00;
      pinDrv_q <= 1'b0;
    end else begin
      tick_q   <= (!thermIn || tickEnd) ? '0 : tick_q + 1'b1; // R18
      pinDrv_q <= pinDrvD;
      if (thInc) thTime_q <= thTime_q + 8'h01; // R18
      else if (wrThTime) thTime_q <= 8'h00;
    end
  end

  // ********************************
  // Read selection
  // ********************************
  wire [7:0] stat2 = {2'b00, pinState, 2'b00, hot_q, // R15
                      monitor_q, failsafe_q};
  wire [7:0] rdMux =
    (ptrCore_q == REG_TEMP)    ? tempRead_q :
    (ptrCore_q == REG_DUTY)    ? duty_q :
    (ptrCore_q == REG_MAXDUTY) ? maxDuty_q :
    (ptrCore_q == REG_STAT2)   ? stat2 :
    (ptrCore_q == REG_VOLT)    ? volt_q : // R17
    (ptrCore_q == REG_LFDIV)   ? lfDiv_q :
    (ptrCore_q == REG_LIMIT)   ? limit_q :
    (ptrCore_q == REG_OFFSET)  ? offset_q :
    (ptrCore_q == REG_THTIME)  ? thTime_q :
    (ptrCore_q == REG_CFG5)    ? cfg5_q :
    (ptrCore_q == REG_CFG4)    ? cfg4_q : 8'h00;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) rdData_q <= 8'h00;
    else rdData_q <= rdMux;
  end

  // ********************************
  // Outputs
  // ********************************
  assign link.rdData     = rdData_q;
  assign fan1DriveOutput = fan1_q;
  assign fan4PinOut      = 1'b0;
  assign fan4PinOe       = ~pinDrv_q;
  assign monitorEnable   = monitor_q;
  assign fanFullSpeed    = fullSpeed;

endmodule : fmcf_core

/* hw/fmcf_pkg.sv */
/*
  Shared constants, register map, field positions and link states of the fan
  monitor control core. Assumes a 100 MHz core clock and an SMBus link clocked
  by its own SCL line.
*/
// Functional notes
// (R1) Frequency bit low: 22.5 kHz fan drive
// (R2) Frequency bit high: 10 to 100 Hz
// (R3) Core supply rising starts monitoring automatically
// (R4) No supply: first addressed transaction starts monitoring
// (R5) Full speed if unaddressed 4.6 s after supply
// (R6) Full speed above thermal limit, default 100 C
// (R7) No supply: no timed fail-safe, writes normal
// (R8) Programming accepted anytime, also after fail-safe
// (R9) Range bit high selects twos complement range
// (R10) Extended range limits reset in offset-64 code
// (R11) Offset register, 0.5 C steps, plus minus 64
// (R12) Fan duty clamped to programmable maximum
// (R13) Config bit 2 sets general pin direction
// (R14) Config bit 3 sets general pin polarity
// (R15) General pin state in status two bit 5
// (R16) Fixed slave address 0x2E, no select pins
// (R17) Voltage ID pins captured at 0x43
// (R18) Thermal event pin timed and driven
// (R19) XOR test puts tree on fan 1
// (R20) Serial bus control; alert on limits
// (R21) Host picks shared pin function, two bits
// (R22) Timer restarts on supply, cancelled by transaction
package fmcf_pkg;

  // Timing
  localparam int CLK_HZ           = 100_000_000;
  localparam int HF_FREQ_HZ       = 22500;
  localparam int LF_MAX_HZ        = 100;
  localparam int LF_MIN_HZ        = 10;
  localparam int FAILSAFE_MS      = 4600;
  localparam int THERMAL_EVENT_PIN_TICK_US    = 1000;
  localparam int HF_PERIOD_DFLT   = CLK_HZ / HF_FREQ_HZ;
  localparam int LF_FAST_DFLT     = CLK_HZ / LF_MAX_HZ;
  localparam int FAILSAFE_DFLT    = (CLK_HZ / 1000) * FAILSAFE_MS;
  localparam int THERMAL_EVENT_PIN_TICK_DFLT  = (CLK_HZ / 1_000_000) * THERMAL_EVENT_PIN_TICK_US;
  localparam logic [3:0] LF_DIV_MAX = 4'(LF_MAX_HZ / LF_MIN_HZ);
  localparam int PWM_W            = 24;
  localparam int FS_W             = 29;
  localparam int TICK_W           = 20;
  localparam int TEMP_W           = 10;

  // Serial bus
  localparam logic [6:0] SMB_ADDR = 7'h2e;

  // Register offsets
  localparam logic [7:0] REG_TEMP     = 8'h25;
  localparam logic [7:0] REG_DUTY     = 8'h30;
  localparam logic [7:0] REG_MAXDUTY  = 8'h38;
  localparam logic [7:0] REG_STAT2    = 8'h42;
  localparam logic [7:0] REG_VOLT     = 8'h43;
  localparam logic [7:0] REG_LFDIV    = 8'h5f;
  localparam logic [7:0] REG_LIMIT    = 8'h6a;
  localparam logic [7:0] REG_OFFSET   = 8'h70;
  localparam logic [7:0] REG_THTIME   = 8'h79;
  localparam logic [7:0] REG_CFG5     = 8'h7c;
  localparam logic [7:0] REG_CFG4     = 8'h7d;

  // Reset values
  localparam logic [7:0] DUTY_RST     = 8'h00;
  localparam logic [7:0] MAXDUTY_RST  = 8'hff;
  localparam logic [7:0] LIMIT_RST    = 8'ha4;
  localparam logic [7:0] OFFSET_RST   = 8'h00;
  localparam logic [7:0] LFDIV_RST    = 8'h01;
  localparam logic [7:0] CFG5_RST     = 8'h00;
  localparam logic [7:0] CFG4_RST     = 8'h00;

  // Field positions
  localparam int CFG5_RANGE    = 0;
  localparam int CFG5_LOWFREQ  = 1;
  localparam int CFG5_GPIO_DIR = 2;
  localparam int CFG5_GPIO_POL = 3;
  localparam int CFG5_GPIO_VAL = 4;
  localparam int CFG4_XOR      = 2;
  localparam int STAT2_FSAFE   = 0;
  localparam int STAT2_MON     = 1;
  localparam int STAT2_HOT     = 2;
  localparam int STAT2_PIN     = 5;

  // Shared pin functions
  localparam logic [1:0] PIN_TACH  = 2'h0;
  localparam logic [1:0] PIN_THERMAL_EVENT_PIN = 2'h1;
  localparam logic [1:0] PIN_ALERT = 2'h2;
  localparam logic [1:0] PIN_GPIO  = 2'h3;

  // Temperature encoding
  localparam logic signed [9:0] EXT_BIAS = 10'sh040;
  localparam logic [7:0] TWOS_MAX = 8'h7f;
  localparam logic [7:0] TWOS_MIN = 8'h81;

  typedef enum logic [2:0] {LK_IDLE, LK_ADDR, LK_CMD, LK_DATA, LK_READ} fmcf_link_e;

endpackage : fmcf_pkg

/* hw/fmcf_link_if.sv */
/*
  Carrier between the SMBus slave (SCL domain) and the core (clock domain).
  Assumes every event crosses as a toggle and data stays stable meanwhile.
*/
`timescale 1ns/100ps
interface fmcf_link_if;
  logic       ptrTgl;
  logic [7:0] ptr;
  logic       wrTgl;
  logic [7:0] wrData;
  logic       doneTgl;
  logic [7:0] rdData;

  modport slave (
    output ptrTgl,
    output ptr,
    output wrTgl,
    output wrData,
    output doneTgl,
    input  rdData
  );

  modport core (
    input  ptrTgl,
    input  ptr,
    input  wrTgl,
    input  wrData,
    input  doneTgl,
    output rdData
  );
endinterface : fmcf_link_if

/* hw/fmcf_smbus_slave.sv */
/*
  SMBus slave: send byte, write byte, receive byte. Runs on SCL; start and
  stop are caught on SDA edges. Assumes open-drain wiring outside.
*/
`timescale 1ns/100ps
module fmcf_smbus_slave (
  input  wire logic  scl,
  input  wire logic  arst_n,
  input  wire logic  sdaIn,
  output logic       sdaOut,
  output logic       sdaOe,
  fmcf_link_if.slave link
);
  import fmcf_pkg::*;

  logic       startTgl_q;
  logic       startAck_q;
  logic       doneTgl_q;
  logic       hit_q;
  logic       sdaDrv_q;
  logic       ptrTgl_q;
  logic       wrTgl_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic [7:0] wrData_q;
  logic [7:0] txByte_q;
  fmcf_link_e state_q;

  wire startPend = startTgl_q ^ startAck_q;
  wire addrHit   = (shift_q[7:1] == SMB_ADDR); // R16
  wire ackBit    = (bitCnt_q == 4'd8);
  wire ackDue    = ackBit && ((state_q == LK_ADDR && addrHit) ||
                   state_q == LK_CMD || state_q == LK_DATA);
  wire txFirst   = (state_q == LK_READ) && (bitCnt_q == 4'd0);
  wire txMore    = (state_q == LK_READ) && (bitCnt_q != 4'd0) && !ackBit;

  // ********************************
  // Start and stop detection
  // ********************************
  always_ff @(negedge sdaIn or negedge arst_n) begin
    if (!arst_n) startTgl_q <= 1'b0;
    else if (scl) startTgl_q <= ~startTgl_q;
  end

  always_ff @(posedge sdaIn or negedge arst_n) begin
    if (!arst_n) doneTgl_q <= 1'b0;
    else if (scl && hit_q) doneTgl_q <= ~doneTgl_q; // R22
  end

  // ********************************
  // Receive side
  // ********************************
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      startAck_q <= 1'b0;
      hit_q      <= 1'b0;
      bitCnt_q   <= 4'd0;
      shift_q    <= 8'h00;
      ptr_q      <= 8'h00;
      ptrTgl_q   <= 1'b0;
      wrData_q   <= 8'h00;
      wrTgl_q    <= 1'b0;
      state_q    <= LK_IDLE;
    end else if (startPend) begin
      startAck_q <= startTgl_q;
      hit_q      <= 1'b0;
      shift_q    <= {7'h00, sdaIn};
      bitCnt_q   <= 4'd1;
      state_q    <= LK_ADDR;
    end else if (state_q != LK_IDLE) begin
      if (!ackBit) begin
        shift_q  <= {shift_q[6:0], sdaIn};
        bitCnt_q <= bitCnt_q + 4'd1;
      end else begin
        bitCnt_q <= 4'd0;
        case (state_q)
          LK_ADDR: begin
            hit_q   <= addrHit;
            state_q <= !addrHit ? LK_IDLE : (shift_q[0] ? LK_READ : LK_CMD);
          end
          LK_CMD: begin
            ptr_q    <= shift_q;
            ptrTgl_q <= ~ptrTgl_q;
            state_q  <= LK_DATA;
          end
          LK_DATA: begin
            wrData_q <= shift_q;
            wrTgl_q  <= ~wrTgl_q; // R20
            state_q  <= LK_IDLE;
          end
          default: state_q <= LK_IDLE;
        endcase
      end
    end
  end

  // ********************************
  // Transmit side and acknowledge
  // ********************************
  always_ff @(negedge scl or negedge arst_n) begin
    if (!arst_n) begin
      sdaDrv_q <= 1'b0;
      txByte_q <= 8'h00;
    end else if (txFirst) begin
      sdaDrv_q <= ~link.rdData[7];
      txByte_q <= {link.rdData[6:0], 1'b0};
    end else if (txMore) begin
      sdaDrv_q <= ~txByte_q[7];
      txByte_q <= {txByte_q[6:0], 1'b0};
    end else begin
      sdaDrv_q <= ackDue;
    end
  end

  assign sdaOut       = 1'b0;
  assign sdaOe        = ~sdaDrv_q;
  assign link.ptr     = ptr_q;
  assign link.ptrTgl  = ptrTgl_q;
  assign link.wrData  = wrData_q;
  assign link.wrTgl   = wrTgl_q;
  assign link.doneTgl = doneTgl_q;

endmodule : fmcf_smbus_slave

/* tb/fmcf_host.sv */
/*
  SMBus host model: makes SCL, pulls or releases SDA.
  Assumes a pull-up on SDA; SCL stands high between frames.
*/
`timescale 1ns/100ps
// ****************
// SMBus host
// ****************
module fmcf_host (
  output logic      scl,
  output logic      sdaDrv,
  input  wire logic sdaIn
);
  import fmcf_pkg::*;
  initial {scl, sdaDrv} = 2'b11;
  task automatic bitX(input logic b, output logic s);
    scl = 1'b0;
    #8 sdaDrv = b;
    #8 scl = 1'b1;
    #8 s = sdaIn;
    #8;
  endtask : bitX
  task automatic cond(input logic a);
    scl = 1'b0;
    #8 sdaDrv = a;
    #8 scl = 1'b1;
    #16 sdaDrv = !a;
    #16;
  endtask : cond
  task automatic byteX(input logic [7:0] d, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bitX(d[i], q[i]);
    bitX(1'b1, k);
    k = !k;
  endtask : byteX
  task automatic probe(input logic [6:0] a, output logic k);
    logic [7:0] q;
    cond(1'b1);
    byteX({a, 1'b0}, q, k);
    cond(1'b0);
  endtask : probe
  task automatic wr(input logic [7:0] r, input logic [7:0] d, output logic k);
    logic [7:0] q;
    logic [2:0] a;
    cond(1'b1);
    byteX({SMB_ADDR, 1'b0}, q, a[0]);
    byteX(r, q, a[1]);
    byteX(d, q, a[2]);
    cond(1'b0);
    k = &a;
  endtask : wr
  task automatic rd(input logic [7:0] r, output logic [7:0] d);
    logic [7:0] q;
    logic       k;
    cond(1'b1);
    byteX({SMB_ADDR, 1'b0}, q, k);
    byteX(r, q, k);
    cond(1'b1);
    byteX({SMB_ADDR, 1'b1}, q, k);
    byteX(8'hff, d, k);
    cond(1'b0);
  endtask : rd
endmodule : fmcf_host

/* tb/fmcf_core_chk.sv */
/*
  Port checker of the fan monitor core: start-up, fail-safe timing, drive.
  Assumes it is bound onto fmcf_core.
*/
`timescale 1ns/100ps
// ****************
// Port checker
// ****************
module fmcf_core_chk #(
  parameter int FAILSAFE_CYC = 200
) (
  input wire logic                        clock,
  input wire logic                        arst_n,
  input wire logic                        scl,
  input wire logic                        sdaOut,
  input wire logic                        sdaOe,
  input wire logic                        processorCoreSupply,
  input wire logic [fmcf_pkg::TEMP_W-1:0] tempIn,
  input wire logic                        fan4PinOut,
  input wire logic                        fan1DriveOutput,
  input wire logic                        monitorEnable,
  input wire logic                        fanFullSpeed
);
  import fmcf_pkg::*;
  localparam int FS_END = FAILSAFE_CYC + 8;
  logic supPrev_q;
  logic supSeen_q;
  logic armed_q;
  int   cnt_q;
  wire  cool = $signed(tempIn) < 10'sd300;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      supPrev_q <= 1'b0;
      supSeen_q <= 1'b0;
      armed_q <= 1'b0;
      cnt_q <= 0;
    end else begin
      supPrev_q <= processorCoreSupply;
      supSeen_q <= supSeen_q | processorCoreSupply;
      if (processorCoreSupply && !supPrev_q) begin
        armed_q <= 1'b1;
        cnt_q <= 0;
      end else if (!scl) begin
        armed_q <= 1'b0;
      end else if (armed_q && cnt_q < FS_END) begin
        cnt_q <= cnt_q + 1;
      end
    end
  end
  sequence s_fullHold;
    fanFullSpeed [*4];
  endsequence
  a_supply_start: assert property ($rose(processorCoreSupply) |-> ##[1:6] monitorEnable)
    else $error("monitor not started by supply");
  a_monitor_hold: assert property (monitorEnable |=> monitorEnable)
    else $error("monitor enable dropped");
  a_fail_timeout: assert property (armed_q && cnt_q == FS_END |-> fanFullSpeed)
    else $error("no full speed after timeout");
  a_fail_early: assert property ($rose(fanFullSpeed) && armed_q && cool
    |-> cnt_q >= FAILSAFE_CYC)
    else $error("full speed too early");
  a_no_supply: assert property (!supSeen_q && cool |-> !fanFullSpeed)
    else $error("full speed without supply");
  a_full_drive: assert property (s_fullHold |-> fan1DriveOutput)
    else $error("fan drive low at full speed");
  a_open_drain: assert property (sdaOut == 1'b0 && fan4PinOut == 1'b0)
    else $error("open drain value high");
  a_ack_edge: assert property ($changed(sdaOe) |-> !scl)
    else $error("data line moved with clock high");
endmodule : fmcf_core_chk

bind fmcf_core fmcf_core_chk #(.FAILSAFE_CYC(FAILSAFE_CYC)) i_chk (
  .clock, .arst_n, .scl, .sdaOut, .sdaOe, .processorCoreSupply, .tempIn,
  .fan4PinOut, .fan1DriveOutput, .monitorEnable, .fanFullSpeed
);

/* tb/test_fmcf_core.sv */
/*
  Self-checking bench of the fan monitor core with an SMBus host model.
  Assumes pull-ups on SDA and on the shared pin.
*/
`timescale 1ns/100ps
// ****************
// Bench top
// ****************
module test_fmcf_core;
  import fmcf_pkg::*;
  localparam int HFP = 64;
  localparam int LFF = 256;
  localparam int FSC = 2000;
  logic        clock, arst_n, scl, sdaDrv, sdaIn, sdaOut, sdaOe;
  logic        processorCoreSupply, voltageIdSixthInput, pinDrv;
  logic [4:0]  voltageIdInput;
  logic [9:0]  tempIn;
  logic        fan4PinIn, fan4PinOut, fan4PinOe, fan1DriveOutput, monitorEnable, fanFullSpeed;
  logic [7:0]  d;
  logic [31:0] n;
  int          checks, failures, cycles;
  assign sdaIn = sdaDrv & (sdaOe | sdaOut);
  assign fan4PinIn = pinDrv & (fan4PinOe | fan4PinOut);
  fmcf_host i_host (.scl, .sdaDrv, .sdaIn);
  fmcf_core #(.HF_PERIOD_CYC(HFP), .LF_FAST_CYC(LFF), .FAILSAFE_CYC(FSC), .THERMAL_EVENT_PIN_TICK_CYC(8))
    i_dut (.clock, .arst_n, .scl, .sdaIn, .sdaOut, .sdaOe, .processorCoreSupply,
    .voltageIdInput, .voltageIdSixthInput, .tempIn, .fan4PinIn, .fan4PinOut,
    .fan4PinOe, .fan1DriveOutput, .monitorEnable, .fanFullSpeed);
  task automatic results();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(negedge clock);
  endtask : tick
  task automatic wr(input logic [7:0] r, input logic [7:0] v);
    logic k;
    i_host.wr(r, v, k);
    chk(k, 1);
    tick(8);
  endtask : wr
  task automatic rd(input logic [7:0] r);
    i_host.rd(r, d);
    tick(8);
  endtask : rd
  task automatic duty(input int p, input int e);
    tick(2 * p);
    n = 0;
    repeat (p) begin
      @(negedge clock);
      n += fan1DriveOutput;
    end
    chk(n, e);
  endtask : duty
  task automatic t_noSupply();
    logic [7:0] rg[7] = '{REG_VOLT, REG_CFG5, REG_CFG4, REG_LIMIT, REG_MAXDUTY, REG_OFFSET, 8'h10};
    logic [7:0] rv[7] = '{8'h2b, 8'h00, 8'h00, 8'ha4, 8'hff, 8'h00, 8'h00};
    logic       k;
    i_host.probe(7'h2f, k);
    chk(k, 0);
    tick(8);
    chk(monitorEnable, 0);
    for (int i = 0; i < 7; i++) begin
      rd(rg[i]);
      chk(d, rv[i]);
    end
    chk(monitorEnable, 1);
    chk(fanFullSpeed, 0);
    $display("t_noSupply done");
  endtask : t_noSupply
  task automatic t_failsafe();
    processorCoreSupply = 1'b1;
    tick(FSC + 20);
    chk(fanFullSpeed, 1);
    duty(HFP, HFP);
    wr(REG_DUTY, 8'h00);
    chk(fanFullSpeed, 0);
    duty(HFP, 0);
    processorCoreSupply = 1'b0;
    tick(8);
    processorCoreSupply = 1'b1;
    tick(FSC / 2);
    wr(REG_DUTY, 8'h00);
    tick(FSC);
    chk(fanFullSpeed, 0);
    $display("t_failsafe done");
  endtask : t_failsafe
  task automatic t_pwm();
    wr(REG_DUTY, 8'h80);
    duty(HFP, HFP / 2);
    wr(REG_MAXDUTY, 8'h40);
    duty(HFP, HFP / 4);
    wr(REG_LFDIV, 8'h02);
    wr(REG_CFG5, 8'h02);
    duty(2 * LFF, LFF / 2);
    wr(REG_CFG5, 8'h00);
    $display("t_pwm done");
  endtask : t_pwm
  task automatic t_hot();
    tempIn = 10'h194;
    tick(8);
    chk(fanFullSpeed, 1);
    tempIn = 10'h18c;
    tick(8);
    chk(fanFullSpeed, 0);
    wr(REG_OFFSET, 8'h06);
    rd(REG_TEMP);
    chk(d, 8'ha6);
    chk(fanFullSpeed, 1);
    wr(REG_OFFSET, 8'h00);
    tempIn = 10'h064;
    wr(REG_CFG5, 8'h01);
    rd(REG_TEMP);
    chk(d, 8'h19);
    chk(fanFullSpeed, 1);
    wr(REG_CFG5, 8'h00);
    chk(fanFullSpeed, 0);
    $display("t_hot done");
  endtask : t_hot
  task automatic t_gpio();
    logic [7:0] cv[5] = '{8'h1c, 8'h0c, 8'h14, 8'h04, 8'h00};
    logic [4:0] ov = 5'b10011;
    wr(REG_CFG4, {6'h0, PIN_GPIO});
    for (int i = 0; i < 5; i++) begin
      wr(REG_CFG5, cv[i]);
      chk(fan4PinOe, ov[4-i]);
    end
    pinDrv = 1'b0;
    rd(REG_STAT2);
    chk(d[5], 1);
    wr(REG_CFG5, 8'h08);
    rd(REG_STAT2);
    chk(d[5], 0);
    wr(REG_CFG4, {6'h0, PIN_THERMAL_EVENT_PIN});
    rd(REG_STAT2);
    chk(d[5], 1);
    tempIn = 10'h194;
    wr(REG_CFG4, {6'h0, PIN_ALERT});
    chk(fan4PinOe, 0);
    tempIn = 10'h064;
    pinDrv = 1'b1;
    $display("t_gpio done");
  endtask : t_gpio
  task automatic t_xor();
    wr(REG_CFG4, 8'h04);
    for (int i = 0; i < 2; i++) begin
      pinDrv = i[0];
      tick(8);
      chk(fan1DriveOutput, ^{voltageIdSixthInput, voltageIdInput,
        processorCoreSupply, fan4PinIn});
    end
    wr(REG_CFG4, 8'h00);
    $display("t_xor done");
  endtask : t_xor
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (++cycles == 60000) begin
      failures++;
      results();
    end
  end
  initial begin
    {checks, failures, cycles} = '0;
    arst_n = 1'b0;
    processorCoreSupply = 1'b0;
    {voltageIdSixthInput, voltageIdInput} = 6'h2b;
    tempIn = 10'h064;
    pinDrv = 1'b1;
    tick(16);
    arst_n = 1'b1;
    t_noSupply();
    t_failsafe();
    t_pwm();
    t_hot();
    t_gpio();
    t_xor();
    results();
  end
endmodule : test_fmcf_core
